/* File: rtl/tmw_timer.sv */
// Module: 16-bit timer, event counter and window counter with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module tmw_timer (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        event_window_input_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    output logic             compare_match_irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]                      timer2_control;
    logic [15:0]                     compare_value;
    logic [15:0]                     count;
    logic [tmw_pkg::PRESCALE_W-1:0]  prescale;
    logic                            tick_prev;
    logic [1:0]                      pin_sync;
    logic                            low_pending;
    logic [4:0]                      blank_count;
    logic                            match_status;
    logic                            match_mask;
    logic                            aw_held;
    logic                            w_held;
    logic [7:0]                      aw_addr;
    logic [31:0]                     w_data;
    logic [3:0]                      w_strb;
    tmw_pkg::tmw_ctrl_s              ctrl;

    // Combinational helpers, one per named decode
    logic                            pin_level;
    logic                            tap_level;
    logic                            source_level;
    logic                            source_rise;
    logic [15:0]                     count_plus;
    logic                            compare_armed;
    logic                            match_hit;
    logic                            aw_take;
    logic                            w_take;
    logic                            ar_take;
    logic                            do_write;
    logic                            wr_control;
    logic                            wr_compare;
    logic                            wr_status;
    logic                            wr_mask;
    logic                            wr_known;
    logic                            low_write;
    logic                            high_write;
    logic                            status_clear;
    logic                            next_status;
    logic                            next_mask;
    logic                            next_aw_held;
    logic                            next_w_held;
    logic                            next_bvalid;
    logic                            next_rvalid;
    logic [31:0]                     read_word;
    logic                            read_known;
    logic [tmw_pkg::PRESCALE_W-1:0]  next_prescale;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    // Fields decoded once and carried together
    assign ctrl.run    = timer2_control[tmw_pkg::CTL_RUN_BIT];
    assign ctrl.source = timer2_control[tmw_pkg::CTL_SRC_LSB +: 3];
    assign ctrl.window = timer2_control[tmw_pkg::CTL_MODE_BIT];

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // Free-running so a source change never restarts the division
    assign next_prescale = prescale + {{(tmw_pkg::PRESCALE_W-1){1'b0}}, 1'b1};
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prescale <= {tmw_pkg::PRESCALE_W{1'b0}};
        end else begin
            prescale <= next_prescale;
        end
    end

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Two stages against metastability; only the second stage is read
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], event_window_input_i};
        end
    end
    assign pin_level = pin_sync[1];

    // ------------------------------------------------------------------
    // Count source
    // ------------------------------------------------------------------
    // Reserved codes give a flat level, so nothing counts
    assign tap_level = (ctrl.source == tmw_pkg::SRC_DIV23)    ? prescale[tmw_pkg::TAP_DIV23] :
                       (ctrl.source == tmw_pkg::SRC_DIV13)    ? prescale[tmw_pkg::TAP_DIV13] :
                       (ctrl.source == tmw_pkg::SRC_DIV8)     ? prescale[tmw_pkg::TAP_DIV8]  :
                       (ctrl.source == tmw_pkg::SRC_DIV3)     ? prescale[tmw_pkg::TAP_DIV3]  :
                       (ctrl.source == tmw_pkg::SRC_EXTERNAL) ? pin_level : 1'b0;
    // Window mode gates the selected clock with the pin level
    assign source_level = ctrl.window ? (pin_level & tap_level) : tap_level;
    // Rising edge; previous level resets low like the idle pin
    assign source_rise = source_level & ~tick_prev;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= source_level;
        end
    end

    // ------------------------------------------------------------------
    // Compare match
    // ------------------------------------------------------------------
    // Match is judged on the increment, so a zero compare fires only when the count wraps from 16'hFFFF
    assign count_plus    = count + 16'h0001;
    assign compare_armed = ~low_pending & (blank_count == 5'h00);
    assign match_hit     = ctrl.run & source_rise & compare_armed & (count_plus == compare_value);

    // Stop clears; a match clears and counting resumes on its own
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count <= tmw_pkg::COUNT_RESET;
        end else if (!ctrl.run) begin
            count <= tmw_pkg::COUNT_RESET;
        end else if (match_hit) begin
            count <= tmw_pkg::COUNT_RESET;
        end else if (source_rise) begin
            count <= count_plus;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Address decode of the held write
    assign wr_control = (aw_addr == tmw_pkg::ADDR_CONTROL);
    assign wr_compare = (aw_addr == tmw_pkg::ADDR_COMPARE);
    assign wr_status  = (aw_addr == tmw_pkg::ADDR_STATUS);
    assign wr_mask    = (aw_addr == tmw_pkg::ADDR_MASK);
    assign wr_known   = wr_control | wr_compare | wr_status | wr_mask;
    assign low_write  = do_write & wr_compare & w_strb[0];
    assign high_write = do_write & wr_compare & w_strb[1];

    // Control register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            timer2_control <= tmw_pkg::CONTROL_RESET;
        end else if (do_write && wr_control && w_strb[0]) begin
            timer2_control <= w_data[7:0];
        end
    end

    // Compare register has no reset branch so it survives a reset
    always_ff @(posedge mclk_i) begin
        if (low_write) begin
            compare_value[7:0] <= w_data[7:0];
        end
        if (high_write) begin
            compare_value[15:8] <= w_data[15:8];
        end
    end

    // Low byte alone leaves the compare half-written; high byte completes it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            low_pending <= 1'b0;
        end else if (high_write) begin
            low_pending <= 1'b0;
        end else if (low_write) begin
            low_pending <= 1'b1;
        end
    end

    // One machine cycle of blanking after the high byte lands
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            blank_count <= 5'h00;
        end else if (high_write) begin
            blank_count <= tmw_pkg::BLANK_LOAD;
        end else if (blank_count != 5'h00) begin
            blank_count <= blank_count - 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Status, mask and interrupt
    // ------------------------------------------------------------------
    // A match in the cycle of a clear wins, so no event is lost
    assign status_clear = do_write & wr_status & w_strb[0] & w_data[0];
    assign next_status  = match_hit | (match_status & ~status_clear);
    assign next_mask    = (do_write & wr_mask & w_strb[0]) ? w_data[0] : match_mask;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            match_status        <= 1'b0;
            match_mask          <= tmw_pkg::MASK_RESET;
            compare_match_irq_o <= 1'b0;
        end else begin
            match_status        <= next_status;
            match_mask          <= next_mask;
            compare_match_irq_o <= next_status & next_mask;
        end
    end

    // ------------------------------------------------------------------
    // Register bus, write side
    // ------------------------------------------------------------------
    // Address and data are taken in any order; the write happens once both are held
    assign aw_take      = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take       = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_take      = s_axi_arvalid_i & s_axi_arready_o;
    assign do_write     = aw_held & w_held;
    assign next_aw_held = do_write ? 1'b0 : (aw_held | aw_take);
    assign next_w_held  = do_write ? 1'b0 : (w_held | w_take);
    assign next_bvalid  = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);
    assign next_rvalid  = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

    // Payload capture needs no reset; it is only used while held
    always_ff @(posedge mclk_i) begin
        if (aw_take) begin
            aw_addr <= s_axi_awaddr_i;
        end
        if (w_take) begin
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end
    end

    // Readies come from flops, so a new request waits one cycle after a response
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bresp_o   <= tmw_pkg::RESP_OKAY;
        end else begin
            aw_held         <= next_aw_held;
            w_held          <= next_w_held;
            s_axi_bvalid_o  <= next_bvalid;
            s_axi_awready_o <= ~next_aw_held & ~next_bvalid;
            s_axi_wready_o  <= ~next_w_held & ~next_bvalid;
            if (do_write) begin
                s_axi_bresp_o <= wr_known ? tmw_pkg::RESP_OKAY : tmw_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register bus, read side
    // ------------------------------------------------------------------
    // Control and compare are write-only and read back as zero
    always_comb begin
        read_word  = 32'h0000_0000;
        read_known = 1'b1;
        if (s_axi_araddr_i == tmw_pkg::ADDR_STATUS) begin
            read_word = {31'h0000_0000, match_status};
        end else if (s_axi_araddr_i == tmw_pkg::ADDR_MASK) begin
            read_word = {31'h0000_0000, match_mask};
        end else if (s_axi_araddr_i == tmw_pkg::ADDR_COUNT) begin
            read_word = {16'h0000, count};
        end else if (s_axi_araddr_i == tmw_pkg::ADDR_CONTROL || s_axi_araddr_i == tmw_pkg::ADDR_COMPARE) begin
            read_word = 32'h0000_0000;
        end else begin
            read_known = 1'b0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= tmw_pkg::RESP_OKAY;
        end else begin
            s_axi_rvalid_o  <= next_rvalid;
            s_axi_arready_o <= ~next_rvalid;
            if (ar_take) begin
                s_axi_rdata_o <= read_word;
                s_axi_rresp_o <= read_known ? tmw_pkg::RESP_OKAY : tmw_pkg::RESP_SLVERR;
            end
        end
    end

endmodule

/* File: rtl/tmw_pkg.sv */
// Package: register map, field layout, reset values and timing constants of the 16-bit window timer
package tmw_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL  = 8'h00;
    localparam logic [7:0] ADDR_COMPARE  = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_MASK     = 8'h0c;
    localparam logic [7:0] ADDR_COUNT    = 8'h10;

    // ------------------------------------------------------------------
    // Control field positions and codes
    // ------------------------------------------------------------------
    localparam int          CTL_MODE_BIT = 1;
    localparam int          CTL_SRC_LSB  = 2;
    localparam int          CTL_RUN_BIT  = 5;
    localparam logic [2:0]  SRC_DIV23    = 3'h0;
    localparam logic [2:0]  SRC_DIV13    = 3'h1;
    localparam logic [2:0]  SRC_DIV8     = 3'h2;
    localparam logic [2:0]  SRC_DIV3     = 3'h3;
    localparam logic [2:0]  SRC_EXTERNAL = 3'h7;

    // Prescaler tap positions: divide by 2^(n) is bit n-1 of a free counter
    localparam int          TAP_DIV23    = 22;
    localparam int          TAP_DIV13    = 12;
    localparam int          TAP_DIV8     = 7;
    localparam int          TAP_DIV3     = 2;
    localparam int          PRESCALE_W   = 23;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [0:0]  MASK_RESET    = 1'h0;
    localparam int          MACHINE_CYCLE_NS = 500;
    localparam int          CLK_PERIOD_NS    = 25;
    localparam int          BLANK_CYCLES     = (MACHINE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0]  BLANK_LOAD       = 5'(BLANK_CYCLES);

    // AXI4-Lite responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Decoded control fields carried as one unit
    typedef struct packed {
        logic       run;
        logic [2:0] source;
        logic       window;
    } tmw_ctrl_s;

endpackage

/* File: verification/tmw_checker.sv */
// Checker: handshake holding on the register bus of the window timer
`timescale 1ns/10ps
module tmw_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_write_take; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o; endsequence
    sequence s_read_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
    // A write taken on both channels is answered within a few cycles
    property p_wanswer; s_write_take |-> ##[1:3] s_axi_bvalid_o; endproperty
    a_wanswer: assert property (p_wanswer) else $error("write response missing");
    property p_ranswer; s_read_take |=> s_axi_rvalid_o; endproperty
    a_ranswer: assert property (p_ranswer) else $error("read data missing");
    // No new address is accepted on a channel while that channel's own answer is outstanding
    property p_awblock; s_axi_bvalid_o |-> !s_axi_awready_o; endproperty
    a_awblock: assert property (p_awblock) else $error("write address taken during response");
    property p_arblock; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
    a_arblock: assert property (p_arblock) else $error("read address taken during response");
    // A response may not vanish before the master took it
    property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o; endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
endmodule

/* File: verification/tmw_pulse.sv */
// Partner model: external event and window pulse source
`timescale 1ns/10ps
module tmw_pulse (input wire logic mclk_i, output logic pin_o);
    logic [4:0] cnt = 5'h00;
    // Sixteen cycles per level keeps the pin rate under fc/16
    always_ff @(posedge mclk_i) cnt <= cnt + 5'h01;
    assign pin_o = cnt[4];
endmodule

/* File: verification/tb.sv */
// Testbench: random compare values in event, timer and window modes
`timescale 1ns/10ps
module tb;
    logic mclk_i = 0, rst_i = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic irq, awready, wready, bvalid, arready, rvalid, pin;
    logic [7:0] addr = 8'h00;
    logic [3:0] strb = 4'hf;
    logic [31:0] wdata = 32'h0, rdata, rd;
    int n_errors = 0, cmp_count = 0;
    tmw_pulse u_src (.mclk_i, .pin_o(pin));
    tmw_timer u_dut (.mclk_i, .rst_i, .event_window_input_i(pin), .s_axi_awaddr_i(addr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wready), .s_axi_bresp_o(), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(addr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .compare_match_irq_o(irq));
    initial forever #12.5 mclk_i = ~mclk_i;
    task automatic chk(string n, logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin n_errors++; $display("FAIL %s expected %h seen %h", n, e, s); end
    endtask
    // Each channel drops valid at the rising edge that takes it; the answer is read at the first edge that shows bvalid or rvalid
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit done;
        done = 0;
        addr <= a;
        wdata <= d;
        strb <= s;
        awv <= w;
        wv <= w;
        bready <= w;
        arv <= !w;
        rready <= !w;
        while (!done) begin
            @(posedge mclk_i);
            if (awready) awv <= 0;
            if (wready) wv <= 0;
            if (arready) arv <= 0;
            if (rvalid) rd = rdata;
            done = bvalid | rvalid;
        end
        bready <= 0;
        rready <= 0;
        @(posedge mclk_i);
    endtask
    task automatic wait_irq();
        repeat (4000) if (!irq) @(negedge mclk_i);
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK"); else $display("Regression broken");
        $finish;
    endtask
    initial begin #500000 n_errors++; summarize; end
    initial begin
        logic [7:0] ctl [3] = '{8'h3c, 8'h2c, 8'h2e}; // Event, timer clock/2^3, window clock/2^3
        void'($urandom(32'h42705988));
        repeat (6) @(posedge mclk_i);
        rst_i <= 0;
        foreach (ctl[i]) begin
            bus(1, 8'h00, 0, 4'hf);
            bus(1, 8'h08, 1, 4'hf);
            bus(1, 8'h04, $urandom_range(5, 2), 4'hf);
            bus(1, 8'h0c, 1, 4'hf);
            // Let the compare blanking run out before starting
            repeat (30) @(posedge mclk_i);
            bus(1, 8'h00, ctl[i], 4'hf);
            wait_irq();
            chk("irq", 1, irq);
            bus(0, 8'h08, 0, 4'hf);
            chk("status", 1, rd[0]);
            bus(1, 8'h08, 1, 4'hf);
            wait_irq();
            chk("irq again", 1, irq);
            bus(1, 8'h00, 0, 4'hf);
            bus(1, 8'h08, 1, 4'hf);
            chk("irq cleared", 0, irq);
            bus(0, 8'h10, 0, 4'hf);
            chk("count stopped", 0, rd);
            $display("test %0d done", i);
        end
        // Low byte alone keeps matches off while the timer runs
        bus(1, 8'h04, 32'h0000_0002, 4'h1);
        bus(1, 8'h00, 8'h2c, 4'hf);
        repeat (300) @(posedge mclk_i);
        chk("low byte only", 0, irq);
        bus(1, 8'h00, 0, 4'hf);
        bus(1, 8'h04, 32'h0000_0000, 4'h2);
        repeat (30) @(posedge mclk_i);
        bus(1, 8'h00, 8'h2c, 4'hf);
        wait_irq();
        chk("high byte arms", 1, irq);
        $display("test compare bytes done");
        // Reset after a stop must keep the compare value
        bus(1, 8'h00, 0, 4'hf);
        bus(1, 8'h08, 1, 4'hf);
        rst_i <= 1;
        repeat (6) @(posedge mclk_i);
        rst_i <= 0;
        bus(0, 8'h0c, 0, 4'hf);
        chk("mask after reset", 0, rd);
        bus(1, 8'h0c, 1, 4'hf);
        bus(1, 8'h00, 8'h2c, 4'hf);
        wait_irq();
        chk("compare kept", 1, irq);
        $display("test reset done");
        summarize;
    end
endmodule
bind tmw_timer tmw_checker u_chk (.mclk_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .s_axi_rready_i);
